// ### smmrs_top.sv
// axi4-lite register block for smm region size and address bits
`timescale 1ns/1ps
// Function
// - code zero disables region, no decode
// - codes 1..7 give 4 KB..256 KB
// - codes 8..14 give 512 KB..32 MB
// - code all ones decodes as 4 KB
// - size field in low nibble, index 23h
// - index CFh accesses address and size together
// - size and address writes only when unlocked or in interrupt mode; mode register writes are never blocked
module smmrs_top
	import smmrs_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_mgmt_interrupt_mode,
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_region_enable,
	output logic [25:0]      o_region_mask,
	output logic [3:0]       o_region_addr
);
	// ==========================================================
	// register state
	logic [3:0]  size_code;
	logic [3:0]  mgmt_region_address_reg;
	logic        mgmt_config_write_lock;
	logic        sw_mode;
	logic        dec_enable;
	logic [25:0] dec_mask;
	logic [11:0] aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        wr_fire;
	logic        wr_allowed;
	logic        wr_hit;
	logic [31:0] next_rdata;
	logic        next_rhit;

	smmrs_size_decode u_dec (
		.i_code   (size_code),
		.o_enable (dec_enable),
		.o_mask   (dec_mask)
	);

	// ==========================================================
	// write channel capture, either order
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (o_awready && i_awvalid) begin
			aw_held <= 1'b1;
			aw_addr <= i_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (o_wready && i_wvalid) begin
			w_held <= 1'b1;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
		end else begin
			o_awready <= !aw_held && !(o_awready && i_awvalid) && !o_bvalid;
			o_wready  <= !w_held && !(o_wready && i_wvalid) && !o_bvalid;
		end
	end

	assign wr_fire    = aw_held && w_held && !o_bvalid;
	assign wr_allowed = (mgmt_config_write_lock == 1'b0)
		|| i_mgmt_interrupt_mode;
	assign wr_hit = (aw_addr == ADDR_CONFIG_CONTROL_THREE)
		|| (aw_addr == ADDR_SIZE_PORT)
		|| (aw_addr == ADDR_REGION_ADDR_SIZE)
		|| (aw_addr == ADDR_MODE_CTRL)
		|| (aw_addr == ADDR_DECODE_STATUS);

	// ==========================================================
	// write response
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (o_bvalid && i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			size_code               <= RST_SIZE;
			mgmt_region_address_reg <= RST_ADDR;
		end else if (wr_fire && wr_allowed && w_strb[0]) begin
			if (aw_addr == ADDR_SIZE_PORT) begin
				size_code <= w_data[SIZE_LSB +: SIZE_W];
			end else if (aw_addr == ADDR_REGION_ADDR_SIZE) begin
				size_code               <= w_data[SIZE_LSB +: SIZE_W];
				mgmt_region_address_reg <= w_data[ADDR_LSB +: SIZE_W];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mgmt_config_write_lock <= RST_LOCK;
		end else if (wr_fire && w_strb[0]
			&& aw_addr == ADDR_CONFIG_CONTROL_THREE) begin
			// lock may be set by anyone, cleared only when writes allowed
			mgmt_config_write_lock <= w_data[LOCK_BIT]
				| (mgmt_config_write_lock & !wr_allowed);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sw_mode <= RST_MODE;
		end else if (wr_fire && w_strb[0] && aw_addr == ADDR_MODE_CTRL) begin
			sw_mode <= w_data[MODE_BIT];
		end
	end

	// ==========================================================
	// read path
	always_comb begin
		next_rdata = 32'h0;
		next_rhit  = 1'b1;
		unique case (i_araddr)
			ADDR_CONFIG_CONTROL_THREE: next_rdata[LOCK_BIT] = mgmt_config_write_lock;
			ADDR_SIZE_PORT: next_rdata[SIZE_LSB +: SIZE_W] = size_code;
			ADDR_REGION_ADDR_SIZE: begin
				next_rdata[SIZE_LSB +: SIZE_W] = size_code;
				next_rdata[ADDR_LSB +: SIZE_W] = mgmt_region_address_reg;
			end
			ADDR_MODE_CTRL: next_rdata[MODE_BIT] = sw_mode;
			ADDR_DECODE_STATUS: next_rdata = {5'h0, dec_enable, dec_mask};
			default: next_rhit = 1'b0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !(o_arready && i_arvalid);
			if (o_arready && i_arvalid) begin
				o_rvalid <= 1'b1;
				o_rdata  <= next_rdata;
				o_rresp  <= next_rhit ? RESP_OKAY : RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// region outputs
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_region_enable <= 1'b0;
			o_region_mask   <= 26'h0;
			o_region_addr   <= RST_ADDR;
		end else begin
			o_region_enable <= dec_enable;
			o_region_mask   <= dec_mask;
			o_region_addr   <= mgmt_region_address_reg;
		end
	end
endmodule : smmrs_top

// ### smmrs_pkg.sv
// package: register map, field layout and reset values for the smm size block
package smmrs_pkg;
	// ==========================================================
	// register offsets (byte addresses = 4 * index)
	localparam logic [7:0]  IDX_CONFIG_CONTROL_THREE = 8'hc3;
	localparam logic [7:0]  IDX_SIZE_PORT            = 8'h23;
	localparam logic [7:0]  IDX_REGION_ADDR_SIZE     = 8'hcf;
	localparam logic [7:0]  IDX_MODE_CTRL            = 8'hf0;
	localparam logic [7:0]  IDX_DECODE_STATUS        = 8'hf1;
	localparam logic [11:0] ADDR_CONFIG_CONTROL_THREE =
		{2'h0, IDX_CONFIG_CONTROL_THREE, 2'h0};
	localparam logic [11:0] ADDR_SIZE_PORT        = {2'h0, IDX_SIZE_PORT, 2'h0};
	localparam logic [11:0] ADDR_REGION_ADDR_SIZE =
		{2'h0, IDX_REGION_ADDR_SIZE, 2'h0};
	localparam logic [11:0] ADDR_MODE_CTRL     = {2'h0, IDX_MODE_CTRL, 2'h0};
	localparam logic [11:0] ADDR_DECODE_STATUS = {2'h0, IDX_DECODE_STATUS, 2'h0};
	// ==========================================================
	// field positions
	localparam int LOCK_BIT      = 0;
	localparam int SIZE_LSB      = 0;
	localparam int SIZE_W        = 4;
	localparam int ADDR_LSB      = 4;
	localparam int MODE_BIT      = 0;
	// ==========================================================
	// size codes
	localparam logic [3:0] SIZE_CODE_OFF     = 4'h0;
	localparam logic [3:0] SIZE_CODE_ALLONES = 4'hf;
	localparam logic [3:0] SIZE_CODE_4K      = 4'h1;
	localparam int         SIZE_SHIFT_4K     = 12;
	// ==========================================================
	// reset values
	localparam logic [3:0] RST_SIZE = 4'h0;
	localparam logic [3:0] RST_ADDR = 4'h0;
	localparam logic       RST_LOCK = 1'b0;
	localparam logic       RST_MODE = 1'b0;
	// ==========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : smmrs_pkg

// ### smmrs_size_decode.sv
// decoder from four-bit size code to region enable and byte mask
`timescale 1ns/1ps
module smmrs_size_decode
	import smmrs_pkg::*;
(
	input  wire logic [3:0]  i_code,
	output logic             o_enable,
	output logic [25:0]      o_mask
);
	logic [3:0] eff_code;
	always_comb begin
		eff_code = i_code;
		if (i_code == SIZE_CODE_ALLONES) begin
			eff_code = SIZE_CODE_4K;
		end
		o_enable = (eff_code != SIZE_CODE_OFF);
		// mask of offset bits: 4 KB << (code-1)
		if (o_enable) begin
			o_mask = 26'((27'h1 << (SIZE_SHIFT_4K + int'(eff_code) - 1)) - 27'h1);
		end else begin
			o_mask = 26'h0;
		end
	end
endmodule : smmrs_size_decode

// ### smmrs_assertions.sv
// checker of the smm size block port behaviour
`timescale 1ns/1ps
module smmrs_checker
	import smmrs_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic        o_region_enable,
	input wire logic [25:0] o_region_mask
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// properties
	sequence s_rd_taken; i_arvalid && o_arready; endsequence
	sequence s_wr_taken; i_wvalid && o_wready; endsequence
	property p_off; !o_region_enable |-> o_region_mask == 26'h0; endproperty
	property p_min; o_region_enable |-> &o_region_mask[11:0]; endproperty
	property p_pow;
		o_region_enable |-> ((o_region_mask + 26'h1) & o_region_mask) == 26'h0;
	endproperty
	property p_rlat; s_rd_taken |=> o_rvalid; endproperty
	property p_wlat; s_wr_taken |-> ##[1:3] o_bvalid; endproperty
	property p_rhold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	property p_chg;
		$changed(o_region_mask) |-> o_bvalid || $past(o_bvalid);
	endproperty
	a_off: assert property (p_off) else $error("mask set while off");
	a_min: assert property (p_min) else $error("mask below 4 KB");
	a_pow: assert property (p_pow) else $error("mask not a power");
	a_rlat: assert property (p_rlat) else $error("read late");
	a_wlat: assert property (p_wlat) else $error("write late");
	a_rhold: assert property (p_rhold) else $error("read dropped");
	a_chg: assert property (p_chg) else $error("size moved alone");
endmodule : smmrs_checker

bind smmrs_top smmrs_checker chk (.*);

// ### smmrs_host.sv
// register bus master model standing for the processor core
`timescale 1ns/1ps
module smmrs_host (
	input  wire logic        i_mclk,
	output logic [11:0]      i_awaddr = 12'h0,
	output logic             i_awvalid = 1'b0,
	output logic [31:0]      i_wdata = 32'h0,
	output logic [3:0]       i_wstrb = 4'hf,
	output logic             i_wvalid = 1'b0,
	output logic             i_bready = 1'b0,
	output logic [11:0]      i_araddr = 12'h0,
	output logic             i_arvalid = 1'b0,
	output logic             i_rready = 1'b0,
	input  wire logic        o_awready,
	input  wire logic        o_wready,
	input  wire logic [1:0]  o_bresp,
	input  wire logic        o_bvalid,
	input  wire logic        o_arready,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_rvalid
);
	// ==========================================================
	// bus cycles
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r, output bit got);
		got = 1'b0;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge i_mclk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) begin
				got = 1'b1;
				r = o_bresp;
				i_bready <= 1'b0;
			end
		end
	endtask : wr
	// rready comes late on purpose, so the slave must hold its answer
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output bit got);
		got = 1'b0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge i_mclk);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid && i_rready) begin
				got = 1'b1;
				d = o_rdata;
				i_rready <= 1'b0;
			end else if (o_rvalid) i_rready <= 1'b1;
		end
	endtask : rd
endmodule : smmrs_host

// ### tb_smmrs_top.sv
// testbench of the smm size block
`timescale 1ns/1ps
module tb_smmrs_top
	import smmrs_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_mgmt_interrupt_mode = 1'b0;
	logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
	logic i_arvalid, o_arready, o_rvalid, i_rready, o_region_enable;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [1:0] o_bresp, o_rresp;
	logic [3:0] i_wstrb, o_region_addr;
	logic [25:0] o_region_mask;
	int err_count = 0;
	int total_checks = 0;
	smmrs_top dut (.*);
	smmrs_host m (.*);
	initial forever #50 i_mclk = ~i_mclk;
	// ==========================================================
	// tasks
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic w(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic [1:0] rs;
		bit g;
		m.wr(a, d, rs, g);
		if (!g) err_count++;
		if (!g) close_out();
		chk({30'h0, rs}, {30'h0, e});
	endtask : w
	task automatic r(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		bit g;
		m.rd(a, d, g);
		if (!g) err_count++;
		if (!g) close_out();
		chk(d, e);
	endtask : r
	function automatic logic [25:0] mask_of(input logic [3:0] c);
		if (c == 4'h0) return 26'h0;
		if (c == 4'hf) return 26'hfff;
		return (26'h1 << (c + 11)) - 26'h1;
	endfunction : mask_of
	// ==========================================================
	// scenarios
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst <= 1'b0;
		r(ADDR_REGION_ADDR_SIZE, 32'h0);
		for (int c = 0; c < 16; c++) begin
			w(ADDR_SIZE_PORT, 32'(c), RESP_OKAY);
			@(posedge i_mclk);
			chk({6'h0, o_region_mask}, {6'h0, mask_of(c[3:0])});
			chk({31'h0, o_region_enable}, {31'h0, c != 0});
			r(ADDR_REGION_ADDR_SIZE, 32'(c));
		end
		w(ADDR_REGION_ADDR_SIZE, 32'ha5, RESP_OKAY);
		r(ADDR_SIZE_PORT, 32'h5);
		chk({28'h0, o_region_addr}, 32'ha);
		w(ADDR_CONFIG_CONTROL_THREE, 32'h1, RESP_OKAY);
		w(ADDR_SIZE_PORT, 32'h3, RESP_OKAY);
		r(ADDR_REGION_ADDR_SIZE, 32'ha5);
		w(ADDR_CONFIG_CONTROL_THREE, 32'h0, RESP_OKAY);
		r(ADDR_CONFIG_CONTROL_THREE, 32'h1);
		i_mgmt_interrupt_mode <= 1'b1;
		w(ADDR_SIZE_PORT, 32'h3, RESP_OKAY);
		r(ADDR_REGION_ADDR_SIZE, 32'ha3);
		w(12'h004, 32'h0, RESP_SLVERR);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		chk({31'h0, o_region_enable}, 32'h0);
		r(ADDR_SIZE_PORT, 32'h0);
		close_out();
	end
endmodule : tb_smmrs_top
